// *** rtl/sac_pkg.sv ***
// Constants and types for the static memory access controller
package sac_pkg;
   // Clock period in picoseconds (20 MHz)
   localparam int unsigned CLK_PERIOD_PS = 50000;
   // Read cycle time, ns (slow grade)
   localparam int unsigned READ_CYCLE_NS = 55;
   // Select, address and lane valid before write end, ns
   localparam int unsigned SELECT_VALID_WINDOW_NS = 45;
   // Write data setup before write end, ns
   localparam int unsigned DATA_SETUP_NS = 25;
   // Strobe pulse width, ns
   localparam int unsigned STROBE_WIDTH_NS = 40;
   // Write strobe low to device output released, ns
   localparam int unsigned STROBE_RELEASE_NS = 20;
   // Retention recovery equals one read cycle
   localparam int unsigned RETENTION_EXIT_RECOVERY_NS = READ_CYCLE_NS;
   // Cycle counts, least times rounded up
   localparam int unsigned READ_CYCLES =
      (READ_CYCLE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned SELECT_CYCLES =
      (SELECT_VALID_WINDOW_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned STROBE_CYCLES =
      (STROBE_WIDTH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RELEASE_CYCLES =
      (STROBE_RELEASE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int unsigned RECOVERY_CYCLES =
      (RETENTION_EXIT_RECOVERY_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   // Write low phase is the longer of the select and strobe windows
   localparam int unsigned WRITE_LOW_CYCLES =
      (SELECT_CYCLES > STROBE_CYCLES) ? SELECT_CYCLES : STROBE_CYCLES;
   // Counter width
   localparam int unsigned CNT_W = 4;
   // Pin widths
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 16;
   // Controller states, Gray coded along the usual path
   typedef enum logic [2:0]
   {
      SAC_IDLE    = 3'h0,
      SAC_READ    = 3'h1,
      SAC_WRITE   = 3'h3,
      SAC_WEND    = 3'h2,
      SAC_RETAIN  = 3'h6,
      SAC_RECOVER = 3'h7
   } sac_state_t;
endpackage

// *** rtl/sac_sync.sv ***
// Three-stage input synchroniser for the read data lines
`timescale 1ns/1ns
`default_nettype none
module sac_sync
#(
   parameter int unsigned WIDTH = 16
)
(
   input  wire logic             clock_in,
   input  wire logic             reset_n_in,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);
   // Stages of the synchroniser
   logic [WIDTH-1:0] stage1_reg;
   logic [WIDTH-1:0] stage2_reg;
   logic [WIDTH-1:0] stage3_reg;

   // --------------------------------------------------------------
   // Shift chain
   // --------------------------------------------------------------
   // First stage is read only by the second
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end
      else
      begin
         stage1_reg <= async_in;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // --------------------------------------------------------------
   // Agreement filter
   // --------------------------------------------------------------
   // Output takes a bit once stages two and three agree
   genvar i;
   generate
      for (i = 0; i < WIDTH; i++)
      begin : g_bit
         always_ff @(posedge clock_in or negedge reset_n_in)
         begin
            if (!reset_n_in)
               sync_out[i] <= 1'b0;
            else if (stage2_reg[i] == stage3_reg[i])
               sync_out[i] <= stage3_reg[i];
         end
      end
   endgenerate
endmodule
`default_nettype wire

// *** rtl/sac_ctrl.sv ***
// Host controller driving a 16-bit asynchronous static memory
//
// What the memory datasheet requires
// RULE1: Write strobe stays high during reads.
// RULE2: Selects, gate, lane held active while reading.
// RULE3: Address valid before primary select falls; here both change on the same clock edge.
// RULE4: Device writes under full select overlap.
// RULE5: Any qualifier released ends the write.
// RULE6: Write data stable before write end.
// RULE7: Write data held through write end.
// RULE8: Address valid long before write end.
// RULE9: Address unchanged until write end.
// RULE10: Selects active long before write end.
// RULE11: Byte lanes valid long before write end.
// RULE12: Device releases data after strobe falls.
// RULE13: Device redrives no sooner after strobe rises.
// RULE14: Output gate level never blocks writes.
// RULE15: Deselect for retention; recover one cycle.
// RULE16: Controller never contends on data lines.
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl
   import sac_pkg::*;
#(
   parameter int unsigned AW = ADDR_W,
   parameter int unsigned DW = DATA_W
)
(
   input  wire logic          clock_in,
   input  wire logic          reset_n_in,
   // User request side
   input  wire logic          req_valid_in,
   input  wire logic          req_write_in,
   input  wire logic [AW-1:0] req_addr_in,
   input  wire logic [DW-1:0] req_wdata_in,
   input  wire logic [1:0]    req_lane_n_in,
   input  wire logic          retain_req_in,
   output var  logic          req_ready_out,
   output var  logic          rdata_valid_out,
   output var  logic [DW-1:0] rdata_out,
   output var  logic          retained_out,
   // Memory pins
   output var  logic [AW-1:0] word_address_out,
   output var  logic          primary_select_n_out,
   output var  logic          secondary_select_out,
   output var  logic          output_gate_n_out,
   output var  logic          write_strobe_n_out,
   output var  logic          low_byte_lane_n_out,
   output var  logic          high_byte_lane_n_out,
   input  wire logic [DW-1:0] shared_data_lines_in,
   output var  logic [DW-1:0] shared_data_lines_out,
   output var  logic          shared_data_lines_oe_out
);
   // Controller state
   sac_state_t       state_reg;
   sac_state_t       state_next;
   // Phase counter
   logic [CNT_W-1:0] count_reg;
   logic [CNT_W-1:0] count_next;
   // Latched request
   logic [AW-1:0]    addr_reg;
   logic [DW-1:0]    wdata_reg;
   logic [1:0]       lane_n_reg;
   logic             is_write_reg;
   // Synchronised read data
   logic [DW-1:0]    rdata_sync;
   // Read result registers
   logic [DW-1:0]    rdata_reg;
   logic             rdata_valid_reg;

   // Read data through four flip-flops
   sac_sync #(.WIDTH(DW)) u_sync
   (
      .clock_in   (clock_in),
      .reset_n_in (reset_n_in),
      .async_in   (shared_data_lines_in),
      .sync_out   (rdata_sync)
   );

   // Narrow a cycle count to the counter width
   function automatic logic [CNT_W-1:0] cnt_of(input int unsigned n);
      cnt_of = CNT_W'(n);
   endfunction

   // ----------------------------------------------------------------
   // State sequencing
   // ----------------------------------------------------------------
   // Next state and counter
   always_comb
   begin
      state_next = state_reg;
      count_next = count_reg;
      case (state_reg)
         SAC_IDLE:
         begin
            count_next = '0;
            // Retention takes priority over new accesses
            if (retain_req_in)
               state_next = SAC_RETAIN;
            else if (req_valid_in && !req_write_in)
               state_next = SAC_READ;
            else if (req_valid_in)
               state_next = SAC_WRITE;
         end
         SAC_READ:
         begin
            // Hold for a read cycle plus synchroniser delay
            count_next = count_reg + 1'b1;
            if (count_reg == cnt_of(READ_CYCLES + 3))
               state_next = SAC_IDLE;
         end
         SAC_WRITE:
         begin
            // RULE10 select window
            count_next = count_reg + 1'b1;
            // One spare cycle beyond the longest window
            if (count_reg == cnt_of(WRITE_LOW_CYCLES))
            begin
               state_next = SAC_WEND;
               count_next = '0;
            end
         end
         SAC_WEND:
         begin
            // One cycle after strobe rises; data and address still held
            state_next = SAC_IDLE;
         end
         SAC_RETAIN:
         begin
            count_next = '0;
            if (!retain_req_in)
               state_next = SAC_RECOVER;
         end
         SAC_RECOVER:
         begin
            // RULE15 recovery wait
            count_next = count_reg + 1'b1;
            if (count_reg == cnt_of(RECOVERY_CYCLES - 1))
               state_next = SAC_IDLE;
         end
         default:
         begin
            state_next = SAC_IDLE;
            count_next = '0;
         end
      endcase
   end

   // State and counter registers
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         state_reg <= SAC_IDLE;
         count_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
         count_reg <= count_next;
      end
   end

   // ----------------------------------------------------------------
   // Request capture
   // ----------------------------------------------------------------
   // RULE9 address held until write end
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         addr_reg     <= '0;
         wdata_reg    <= '0;
         lane_n_reg   <= 2'h3;
         is_write_reg <= 1'b0;
      end
      else if (state_reg == SAC_IDLE && req_valid_in && !retain_req_in)
      begin
         addr_reg     <= req_addr_in;
         wdata_reg    <= req_wdata_in;
         lane_n_reg   <= req_lane_n_in;
         is_write_reg <= req_write_in;
      end
   end

   // ----------------------------------------------------------------
   // Pin drive
   // ----------------------------------------------------------------
   // Address and data always from registers
   // RULE8 address set with selects
   assign word_address_out      = addr_reg;
   // RULE6 RULE7 data set and held
   assign shared_data_lines_out = wdata_reg;

   // Control pins registered from next state
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         primary_select_n_out     <= 1'b1;
         secondary_select_out     <= 1'b0;
         output_gate_n_out        <= 1'b1;
         write_strobe_n_out       <= 1'b1;
         low_byte_lane_n_out      <= 1'b1;
         high_byte_lane_n_out     <= 1'b1;
         shared_data_lines_oe_out <= 1'b0;
      end
      else
      begin
         // RULE5 release ends write
         // RULE3 selects assert on the same edge as the address latch
         primary_select_n_out <= !(state_next == SAC_READ || state_next == SAC_WRITE);
         secondary_select_out <= (state_next == SAC_READ || state_next == SAC_WRITE);
         // RULE2 gate active through read
         output_gate_n_out    <= !(state_next == SAC_READ);
         // RULE1 strobe only in write phase
         write_strobe_n_out   <= !(state_next == SAC_WRITE);
         // RULE11 lanes for whole access
         low_byte_lane_n_out  <= !((state_next == SAC_READ || state_next == SAC_WRITE)
                                   && !lane_n_next(0));
         high_byte_lane_n_out <= !((state_next == SAC_READ || state_next == SAC_WRITE)
                                   && !lane_n_next(1));
         // RULE16 drive only in write and its end cycle
         shared_data_lines_oe_out <= (state_next == SAC_WRITE || state_next == SAC_WEND);
      end
   end

   // Lane select for the access being entered
   function automatic logic lane_n_next(input int unsigned idx);
      lane_n_next = (state_reg == SAC_IDLE) ? req_lane_n_in[idx] : lane_n_reg[idx];
   endfunction

   // ----------------------------------------------------------------
   // Read capture
   // ----------------------------------------------------------------
   // Data sampled on the last read cycle
   always_ff @(posedge clock_in or negedge reset_n_in)
   begin
      if (!reset_n_in)
      begin
         rdata_reg       <= '0;
         rdata_valid_reg <= 1'b0;
      end
      else
      begin
         rdata_valid_reg <= 1'b0;
         if (state_reg == SAC_READ && count_reg == cnt_of(READ_CYCLES + 3))
         begin
            rdata_reg       <= rdata_sync;
            rdata_valid_reg <= 1'b1;
         end
      end
   end

   assign rdata_out       = rdata_reg;
   assign rdata_valid_out = rdata_valid_reg;
   assign req_ready_out   = (state_reg == SAC_IDLE) && !retain_req_in;
   // RULE15 deselected while retained
   assign retained_out    = (state_reg == SAC_RETAIN);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   // Strobe stays high while gate active
   property p_strobe_read;
      @(posedge clock_in) disable iff (!reset_n_in)
      !output_gate_n_out |-> write_strobe_n_out;
   endproperty
   a_strobe_read: assert property (p_strobe_read) else $error("strobe low in read"); // RULE1

   // Read keeps selects and gate stable
   property p_read_hold;
      @(posedge clock_in) disable iff (!reset_n_in)
      $fell(output_gate_n_out) |-> (!primary_select_n_out && secondary_select_out
         && !output_gate_n_out) [*6] ##1 output_gate_n_out;
   endproperty
   a_read_hold: assert property (p_read_hold) else $error("read dropped early"); // RULE2

   // Address stable while select low
   property p_addr_stable;
      @(posedge clock_in) disable iff (!reset_n_in)
      !primary_select_n_out && !$fell(primary_select_n_out) |-> $stable(word_address_out);
   endproperty
   a_addr_stable: assert property (p_addr_stable) else $error("address moved"); // RULE3

   // Write low phase long enough
   property p_write_len;
      @(posedge clock_in) disable iff (!reset_n_in)
      $fell(write_strobe_n_out) |-> !write_strobe_n_out [*2];
   endproperty
   a_write_len: assert property (p_write_len) else $error("write too short"); // RULE10

   // Data driven through strobe rise
   property p_data_hold;
      @(posedge clock_in) disable iff (!reset_n_in)
      $rose(write_strobe_n_out) |-> shared_data_lines_oe_out && $stable(shared_data_lines_out);
   endproperty
   a_data_hold: assert property (p_data_hold) else $error("data hold lost"); // RULE7

   // Address held through strobe rise
   property p_addr_hold;
      @(posedge clock_in) disable iff (!reset_n_in)
      $rose(write_strobe_n_out) |-> $stable(word_address_out);
   endproperty
   a_addr_hold: assert property (p_addr_hold) else $error("address hold lost"); // RULE9

   // Data driven before strobe falls ends
   property p_data_setup;
      @(posedge clock_in) disable iff (!reset_n_in)
      !write_strobe_n_out |-> shared_data_lines_oe_out;
   endproperty
   a_data_setup: assert property (p_data_setup) else $error("data not driven"); // RULE6

   // No drive while gate active
   property p_no_contend;
      @(posedge clock_in) disable iff (!reset_n_in)
      !output_gate_n_out |-> !shared_data_lines_oe_out;
   endproperty
   a_no_contend: assert property (p_no_contend) else $error("bus contention"); // RULE16

   // Deselected throughout retention
   property p_retain;
      @(posedge clock_in) disable iff (!reset_n_in)
      retained_out |-> primary_select_n_out && !secondary_select_out;
   endproperty
   a_retain: assert property (p_retain) else $error("selected in retention"); // RULE15

   c_read:   cover property (@(posedge clock_in) $fell(output_gate_n_out));
   c_write:  cover property (@(posedge clock_in) $rose(write_strobe_n_out));
   c_retain: cover property (@(posedge clock_in) $fell(retained_out));
endmodule
`default_nettype wire

// *** verif/sac_mem_model.sv ***
// Behavioural model of the 16-bit asynchronous static memory
`timescale 1ns/1ns
`default_nettype none
module sac_mem_model
(
   input  wire logic [15:0] word_address_in,
   input  wire logic        primary_select_n_in,
   input  wire logic        secondary_select_in,
   input  wire logic        output_gate_n_in,
   input  wire logic        write_strobe_n_in,
   input  wire logic        low_byte_lane_n_in,
   input  wire logic        high_byte_lane_n_in,
   input  wire logic [15:0] data_in,
   output var  logic [15:0] data_out,
   output wire logic        drive_out
);
   // ----------------------------------------
   // Storage and selection
   // ----------------------------------------
   logic [15:0] mem [0:65535];   // Word array
   logic [15:0] last_q = 16'h0000; // Last word put on the lines
   wire  logic  sel_w;           // Both selects active
   wire  logic  lane_w;          // Any lane active
   wire  logic  wr_act;          // Internal write overlap
   wire  logic  wr_dly;          // Overlap seen after pins settle
   wire  logic  rd_en;           // Output drivers on

   assign sel_w  = !primary_select_n_in && secondary_select_in;
   assign lane_w = !(low_byte_lane_n_in && high_byte_lane_n_in);
   assign wr_act = sel_w && !write_strobe_n_in && lane_w;
   // Late copy keeps a stale address out of the array at write start
   assign #1 wr_dly = wr_act;
   // drive after 5 ns, release at once
   assign #(5,0) rd_en = sel_w && !output_gate_n_in && write_strobe_n_in && lane_w;
   assign drive_out = rd_en;

   // ----------------------------------------
   // Write path: stores selected bytes
   // ----------------------------------------
   always @*
   begin
      if (wr_dly && wr_act && !low_byte_lane_n_in)
         mem[word_address_in][7:0] = data_in[7:0];
      if (wr_dly && wr_act && !high_byte_lane_n_in)
         mem[word_address_in][15:8] = data_in[15:8];
   end

   // ----------------------------------------
   // Read path: released lanes show inverse of last
   // ----------------------------------------
   always @(rd_en or word_address_in)
   begin
      if (rd_en)
         last_q = mem[word_address_in];
   end
   always_comb
   begin
      data_out[7:0]  = (rd_en && !low_byte_lane_n_in) ? last_q[7:0] : ~last_q[7:0];
      data_out[15:8] = (rd_en && !high_byte_lane_n_in) ? last_q[15:8] : ~last_q[15:8];
   end
endmodule
`default_nettype wire

// *** verif/sac_ctrl_bench.sv ***
// Self-checking bench for the static memory access controller
`timescale 1ns/1ns
`default_nettype none
module sac_ctrl_bench
   import sac_pkg::*;
;
   // ----------------------------------------
   // Signals
   // ----------------------------------------
   logic        clock_in, reset_n_in;   // Clock and reset
   logic        req_valid, req_write;   // Request strobe and kind
   logic [15:0] req_addr, req_wdata;    // Request address and data
   logic [1:0]  req_lane_n;             // Request lanes
   logic        retain_req;             // Retention request
   logic        ready, rvalid, retained; // Status
   logic [15:0] rdata, addr, ctrl_dq;   // Read data, pins
   logic        pri, sec, gate, stb, lo, hi, oe; // Control pins
   logic [15:0] mem_dq;                 // Model data lines
   wire  logic  mem_drive;              // Model drives lines
   wire  logic [15:0] bus;              // Resolved data lines
   int          miscompares = 0;        // Mismatch count
   int          check_count = 0;        // Comparison count

   assign bus = oe ? ctrl_dq : mem_dq;

   sac_ctrl dut_u (.clock_in(clock_in), .reset_n_in(reset_n_in), .req_valid_in(req_valid),
      .req_write_in(req_write), .req_addr_in(req_addr), .req_wdata_in(req_wdata),
      .req_lane_n_in(req_lane_n), .retain_req_in(retain_req), .req_ready_out(ready),
      .rdata_valid_out(rvalid), .rdata_out(rdata), .retained_out(retained),
      .word_address_out(addr), .primary_select_n_out(pri), .secondary_select_out(sec),
      .output_gate_n_out(gate), .write_strobe_n_out(stb), .low_byte_lane_n_out(lo),
      .high_byte_lane_n_out(hi), .shared_data_lines_in(bus), .shared_data_lines_out(ctrl_dq),
      .shared_data_lines_oe_out(oe));

   sac_mem_model mem_u (.word_address_in(addr), .primary_select_n_in(pri),
      .secondary_select_in(sec), .output_gate_n_in(gate), .write_strobe_n_in(stb),
      .low_byte_lane_n_in(lo), .high_byte_lane_n_in(hi), .data_in(bus), .data_out(mem_dq),
      .drive_out(mem_drive));

   // ----------------------------------------
   // Clock, compare and closing
   // ----------------------------------------
   always #25 clock_in = ~clock_in;

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d, mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Both sides must never drive the lines together
   always @(negedge clock_in)
   begin
      if (reset_n_in)
         check({15'h0000, oe & mem_drive}, 16'h0000);
   end

   // Cut a hang short
   initial
   begin
      #200000;
      miscompares++;
      finish_test;
   end

   // ----------------------------------------
   // Request helper: waits ready, one taken edge
   // ----------------------------------------
   task automatic start(input logic w, input logic [15:0] a, d, input logic [1:0] ln);
      for (int i = 0; i < 40 && ready !== 1'b1; i++)
      begin
         @(posedge clock_in);
         #5;
      end
      req_write = w;
      req_addr = a;
      req_wdata = d;
      req_lane_n = ln;
      req_valid = 1'b1;
      @(posedge clock_in);
      #5 req_valid = 1'b0;
   endtask

   // Write walk: two strobe cycles, held data, then release
   task automatic do_write(input logic [15:0] a, d, input logic [1:0] ln);
      start(1'b1, a, d, ln);
      repeat (2)
      begin
         check({pri, sec, stb, lo, hi, oe}, {1'b0, 1'b1, 1'b0, ln[0], ln[1], 1'b1});
         check(addr, a);
         check(ctrl_dq, d);
         @(posedge clock_in);
         #5;
      end
      check({pri, sec, stb, lo, hi, oe}, 16'h002F);
      check(addr ^ ctrl_dq, a ^ d);
      check(addr, a);
      @(posedge clock_in);
      #5;
      check({oe, ready}, 16'h0001);
   endtask

   // Read walk: pins checked once, strobe high until the data pulse
   task automatic do_read(input logic [15:0] a, input logic [1:0] ln, input logic [15:0] exp);
      logic [15:0] m;
      int n;
      m = {{8{~ln[1]}}, {8{~ln[0]}}};
      n = 0;
      start(1'b0, a, 16'h0000, ln);
      @(posedge clock_in);
      #5;
      check({pri, sec, gate, lo, hi}, {1'b0, 1'b1, 1'b0, ln[0], ln[1]});
      check(addr, a);
      while (rvalid !== 1'b1 && n < 30)
      begin
         check(stb, 1'b1);
         @(posedge clock_in);
         #5;
         n++;
      end
      check(rvalid, 1'b1);
      check(rdata & m, exp & m);
   endtask

   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic t_reset;
      check({pri, sec, gate, stb, lo, hi, oe, ready}, 16'h00BD);
   endtask

   task automatic t_words;
      do_write(16'hFFFF, 16'hA55A, 2'b00);
      do_write(16'h0000, 16'h1234, 2'b00);
      do_read(16'hFFFF, 2'b00, 16'hA55A);
      do_read(16'h0000, 2'b00, 16'h1234);
   endtask

   task automatic t_lanes;
      do_write(16'h0100, 16'h1234, 2'b00);
      do_write(16'h0100, 16'hABCD, 2'b10);
      do_write(16'h0100, 16'h5A00, 2'b01);
      do_read(16'h0100, 2'b00, 16'h5ACD);
      do_read(16'h0100, 2'b01, 16'h5A00);
      do_read(16'h0100, 2'b10, 16'h00CD);
   endtask

   task automatic t_retain;
      int n;
      n = 0;
      retain_req = 1'b1;
      req_write = 1'b0;
      req_valid = 1'b1;
      repeat (4) @(posedge clock_in);
      #5;
      check({retained, ready, pri, sec, rvalid}, 16'h0014);
      req_valid = 1'b0;
      @(posedge clock_in);
      #5 retain_req = 1'b0;
      while (ready !== 1'b1 && n < 20)
      begin
         @(posedge clock_in);
         #5;
         n++;
      end
      check(16'(n >= RECOVERY_CYCLES), 16'h0001);
      do_read(16'h0000, 2'b00, 16'h1234);
   endtask

   // ----------------------------------------
   // Main sequence
   // ----------------------------------------
   initial
   begin
      clock_in = 1'b0;
      reset_n_in = 1'b0;
      req_valid = 1'b0;
      req_write = 1'b0;
      req_addr = 16'h0000;
      req_wdata = 16'h0000;
      req_lane_n = 2'b11;
      retain_req = 1'b0;
      repeat (8) @(posedge clock_in);
      #5 reset_n_in = 1'b1;
      t_reset;
      t_words;
      t_lanes;
      t_retain;
      finish_test;
   end
endmodule
`default_nettype wire
